// ### rtl/csh_regs.svh
// Register offsets, field positions, reset values and response constants of the command handler.
// How it works
// - A clear-status command zeroes the event status, operation and questionable event registers except for events of the same cycle, the status byte and
//   the error queue, and leaves every enable register alone.
// - The identification query answers with four comma-separated fields: maker, model, serial number and firmware revision as major.minor.
// - The operation-complete command clears event status bit 0, which is set again only once all earlier work and output changes have finished.
// - A pending operation-complete bit never holds up the parsing of later commands.
// - The operation-complete query answers ASCII 0 while work begun before the last operation-complete command is unfinished, and ASCII 1 after.
// - Reading the event status after an operation-complete command shows 0 while busy and 1 once done.
// - The reset command sets voltage and current setpoints to zero and both protection limits to rated value plus ten percent.
// - The self-test query runs the internal test and answers 1 on pass and 0 on failure.
// - Integers travel in plain integer form.
// - A leading asterisk marks a common command, apart from the colon-rooted subsystem tree.
// - A message terminator or a root specifier returns the parser to the tree root.
`ifndef CSH_REGS_SVH
`define CSH_REGS_SVH
`define CSH_A_IRQ_STATUS 4'h0
`define CSH_A_IRQ_MASK 4'h1
`define CSH_A_ESR 4'h2
`define CSH_A_STB 4'h3
`define CSH_A_OPER_EVENT 4'h4
`define CSH_A_OPER_ENABLE 4'h5
`define CSH_A_QUES_EVENT 4'h6
`define CSH_A_QUES_ENABLE 4'h7
`define CSH_A_ERR_COUNT 4'h8
`define CSH_A_OPC_STATE 4'h9
`define CSH_IRQ_OPC_DONE 0
`define CSH_IRQ_CMD_ERR 1
`define CSH_IRQ_RESP_DONE 2
`define CSH_IRQ_RST_DONE 3
`define CSH_ESR_OPC 0
`define CSH_ESR_CME 5
`define CSH_STB_ERRQ 2
`define CSH_STB_QUES 3
`define CSH_STB_ESB 5
`define CSH_STB_OPER 7
`define CSH_RST_REG8 8'h00
`define CSH_ERR_MAX 4'hf
`define CSH_RATED_V 16'h0bb8
`define CSH_RATED_I 16'h0fa0
`define CSH_LIMIT_V (`CSH_RATED_V + `CSH_RATED_V / 16'h000a)
`define CSH_LIMIT_I (`CSH_RATED_I + `CSH_RATED_I / 16'h000a)
// Identity string is arbitrary: maker, model, serial, firmware major.minor, line feed.
`define CSH_IDN_STR "ACME,PSU0,000000,1.0\n"
`define CSH_IDN_LEN 6'd21
`define CSH_IDN_PAD 88'h0
`define CSH_CH_STAR 8'h2a
`define CSH_CH_COLON 8'h3a
`define CSH_CH_SEMI 8'h3b
`define CSH_CH_LF 8'h0a
`define CSH_CH_SPACE 8'h20
`define CSH_CH_ZERO 8'h30
`define CSH_HDR_MAX 3'd5
`endif

// ### rtl/csh_pkg.sv
// Types of the common status command handler.
package csh_pkg;
    typedef logic [3:0] csh_addr_t;
    typedef logic [7:0] csh_byte_t;
    typedef logic [15:0] csh_level_t;
    typedef enum logic [1:0] {
        CSH_IDLE = 2'b00,
        CSH_TEST = 2'b01,
        CSH_SEND = 2'b11
    } csh_state_t;
endpackage

// ### rtl/csh_handler.sv
// Common command interpreter with status registers, output queue and register port.
`include "csh_regs.svh"
module csh_handler (
    input wire logic clk,
    input wire logic arst_n,
    input wire csh_pkg::csh_byte_t rx_data,
    input wire logic rx_valid,
    output logic rx_ready,
    output csh_pkg::csh_byte_t tx_data,
    output logic tx_valid,
    input wire logic tx_ready,
    input wire logic ops_busy,
    input wire csh_pkg::csh_byte_t oper_set,
    input wire csh_pkg::csh_byte_t ques_set,
    output logic selftest_start,
    input wire logic selftest_done,
    input wire logic selftest_pass,
    output csh_pkg::csh_level_t voltage_setpoint,
    output csh_pkg::csh_level_t current_setpoint,
    output csh_pkg::csh_level_t overvoltage_limit,
    output csh_pkg::csh_level_t overcurrent_limit,
    output logic output_on,
    input wire csh_pkg::csh_addr_t reg_addr,
    input wire csh_pkg::csh_byte_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output csh_pkg::csh_byte_t reg_rdata,
    output logic irq
);
    import csh_pkg::*;

    csh_state_t state;
    logic [255:0] resp;
    logic [5:0] resp_len;
    logic [39:0] hdr;
    logic [2:0] hdr_len;
    logic in_common;
    logic in_subsys;
    logic hdr_bad;
    logic opc_armed;
    csh_byte_t esr;
    csh_byte_t oper_event;
    csh_byte_t oper_enable;
    csh_byte_t ques_event;
    csh_byte_t ques_enable;
    csh_byte_t stb;
    csh_byte_t irq_status;
    csh_byte_t irq_mask;
    logic [3:0] err_count;

    logic take;
    logic term;
    logic is_cls;
    logic is_idn;
    logic is_opc;
    logic is_opcq;
    logic is_rst;
    logic is_tst;
    logic is_esrq;
    logic cmd_err;
    logic opc_done;
    logic resp_last;
    logic cls_now;
    logic esr_rd_clr;
    csh_byte_t next_esr;
    csh_byte_t irq_evt;
    logic [7:0] upc;

    function automatic logic [39:0] csh_hdr5(input logic [39:0] s);
        return s;
    endfunction

    // Builds an integer answer with no leading zeros, then a line feed.
    function automatic logic [255:0] csh_nr1(input csh_byte_t v);
        logic [7:0] d2;
        logic [7:0] d1;
        logic [7:0] d0;
        d2 = 8'(v / 8'd100) + `CSH_CH_ZERO;
        d1 = 8'((v / 8'd10) % 8'd10) + `CSH_CH_ZERO;
        d0 = 8'(v % 8'd10) + `CSH_CH_ZERO;
        if (v >= 8'd100) begin
            return {d2, d1, d0, `CSH_CH_LF, 224'h0};
        end else if (v >= 8'd10) begin
            return {d1, d0, `CSH_CH_LF, 232'h0};
        end
        return {d0, `CSH_CH_LF, 240'h0};
    endfunction

    function automatic logic [5:0] csh_nr1_len(input csh_byte_t v);
        if (v >= 8'd100) begin
            return 6'd4;
        end else if (v >= 8'd10) begin
            return 6'd3;
        end
        return 6'd2;
    endfunction

    assign take = rx_valid && rx_ready;
    assign upc = (rx_data >= 8'h61 && rx_data <= 8'h7a) ? (rx_data - 8'h20) : rx_data;
    assign term = take && (rx_data == `CSH_CH_LF || rx_data == `CSH_CH_SEMI);
    assign is_cls = term && in_common && !hdr_bad && hdr == csh_hdr5({16'h0, "CLS"});
    assign is_idn = term && in_common && !hdr_bad && hdr == csh_hdr5({8'h0, "IDN?"});
    assign is_opc = term && in_common && !hdr_bad && hdr == csh_hdr5({16'h0, "OPC"});
    assign is_opcq = term && in_common && !hdr_bad && hdr == csh_hdr5({8'h0, "OPC?"});
    assign is_rst = term && in_common && !hdr_bad && hdr == csh_hdr5({16'h0, "RST"});
    assign is_tst = term && in_common && !hdr_bad && hdr == csh_hdr5({8'h0, "TST?"});
    assign is_esrq = term && in_common && !hdr_bad && hdr == csh_hdr5({8'h0, "ESR?"});
    assign cmd_err = term && in_common &&
        !(is_cls || is_idn || is_opc || is_opcq || is_rst || is_tst || is_esrq);
    assign opc_done = opc_armed && !ops_busy && !is_opc;
    assign resp_last = tx_valid && tx_ready && resp_len == 6'd1;
    assign cls_now = is_cls;
    assign esr_rd_clr = is_esrq;
    assign tx_data = resp[255:248];

    // Header collection: asterisk opens a common header, colon a subsystem one.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hdr <= 40'h0;
            hdr_len <= 3'd0;
            in_common <= 1'b0;
            in_subsys <= 1'b0;
            hdr_bad <= 1'b0;
        end else if (term) begin
            hdr <= 40'h0;
            hdr_len <= 3'd0;
            in_common <= 1'b0;
            in_subsys <= 1'b0;
            hdr_bad <= 1'b0;
        end else if (take) begin
            if (!in_common && !in_subsys && rx_data == `CSH_CH_STAR) begin
                in_common <= 1'b1;
            end else if (rx_data == `CSH_CH_COLON) begin
                in_common <= 1'b0;
                in_subsys <= 1'b1;
                hdr <= 40'h0;
                hdr_len <= 3'd0;
            end else if (in_common && rx_data != `CSH_CH_SPACE) begin
                hdr <= {hdr[31:0], upc};
                if (hdr_len == `CSH_HDR_MAX) begin
                    hdr_bad <= 1'b1;
                end else begin
                    hdr_len <= hdr_len + 3'd1;
                end
            end
        end
    end

    // Answer sequencing; parsing carries on while an operation-complete is pending.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= CSH_IDLE;
            resp <= 256'h0;
            resp_len <= 6'd0;
            tx_valid <= 1'b0;
            rx_ready <= 1'b0;
            selftest_start <= 1'b0;
        end else begin
            selftest_start <= 1'b0;
            case (state)
                CSH_IDLE: begin
                    rx_ready <= 1'b1;
                    if (is_idn) begin
                        resp <= {`CSH_IDN_STR, `CSH_IDN_PAD};
                        resp_len <= `CSH_IDN_LEN;
                        tx_valid <= 1'b1;
                        rx_ready <= 1'b0;
                        state <= CSH_SEND;
                    end else if (is_opcq) begin
                        resp <= csh_nr1({7'h0, !opc_armed});
                        resp_len <= 6'd2;
                        tx_valid <= 1'b1;
                        rx_ready <= 1'b0;
                        state <= CSH_SEND;
                    end else if (is_esrq) begin
                        resp <= csh_nr1(next_esr);
                        resp_len <= csh_nr1_len(next_esr);
                        tx_valid <= 1'b1;
                        rx_ready <= 1'b0;
                        state <= CSH_SEND;
                    end else if (is_tst) begin
                        selftest_start <= 1'b1;
                        rx_ready <= 1'b0;
                        state <= CSH_TEST;
                    end
                end
                CSH_TEST: begin
                    if (selftest_done) begin
                        resp <= csh_nr1({7'h0, selftest_pass});
                        resp_len <= 6'd2;
                        tx_valid <= 1'b1;
                        state <= CSH_SEND;
                    end
                end
                CSH_SEND: begin
                    if (tx_valid && tx_ready) begin
                        resp <= {resp[247:0], 8'h0};
                        resp_len <= resp_len - 6'd1;
                    end
                    if (resp_last) begin
                        tx_valid <= 1'b0;
                        rx_ready <= 1'b1;
                        state <= CSH_IDLE;
                    end
                end
                default: begin
                    tx_valid <= 1'b0;
                    state <= CSH_IDLE;
                end
            endcase
        end
    end

    // Event status: value as it stands after this cycle's events, before any clear.
    always_comb begin
        next_esr = esr;
        if (opc_done) begin
            next_esr[`CSH_ESR_OPC] = 1'b1;
        end
        if (cmd_err) begin
            next_esr[`CSH_ESR_CME] = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            esr <= `CSH_RST_REG8;
            opc_armed <= 1'b0;
        end else begin
            if (is_opc) begin
                esr[`CSH_ESR_OPC] <= 1'b0;
                opc_armed <= 1'b1;
            end else if (opc_done) begin
                esr[`CSH_ESR_OPC] <= 1'b1;
                opc_armed <= 1'b0;
            end
            if (cmd_err) begin
                esr[`CSH_ESR_CME] <= 1'b1;
            end
            if (esr_rd_clr) begin
                esr <= `CSH_RST_REG8;
            end else if (cls_now) begin
                // A completion that lands in the clearing cycle is kept.
                esr <= `CSH_RST_REG8;
                esr[`CSH_ESR_OPC] <= opc_done;
            end
        end
    end

    // Operation and questionable events, status byte and error queue.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            oper_event <= `CSH_RST_REG8;
            ques_event <= `CSH_RST_REG8;
            err_count <= 4'h0;
            stb <= `CSH_RST_REG8;
        end else begin
            if (cls_now) begin
                oper_event <= oper_set;
                ques_event <= ques_set;
                err_count <= 4'h0;
                stb <= `CSH_RST_REG8;
            end else begin
                oper_event <= oper_event | oper_set;
                ques_event <= ques_event | ques_set;
                if (cmd_err && err_count != `CSH_ERR_MAX) begin
                    err_count <= err_count + 4'h1;
                end
                stb <= 8'h0;
                stb[`CSH_STB_ERRQ] <= err_count != 4'h0;
                stb[`CSH_STB_QUES] <= |(ques_event & ques_enable);
                stb[`CSH_STB_ESB] <= esr != 8'h0;
                stb[`CSH_STB_OPER] <= |(oper_event & oper_enable);
            end
        end
    end

    // Output levels: power-on and the reset command load the same defaults.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            voltage_setpoint <= 16'h0;
            current_setpoint <= 16'h0;
            overvoltage_limit <= `CSH_LIMIT_V;
            overcurrent_limit <= `CSH_LIMIT_I;
            output_on <= 1'b0;
        end else if (is_rst) begin
            voltage_setpoint <= 16'h0;
            current_setpoint <= 16'h0;
            overvoltage_limit <= `CSH_LIMIT_V;
            overcurrent_limit <= `CSH_LIMIT_I;
            output_on <= 1'b0;
        end
    end

    // Register port: enables, interrupt status and mask.
    always_comb begin
        irq_evt = 8'h0;
        irq_evt[`CSH_IRQ_OPC_DONE] = opc_done;
        irq_evt[`CSH_IRQ_CMD_ERR] = cmd_err;
        irq_evt[`CSH_IRQ_RESP_DONE] = resp_last;
        irq_evt[`CSH_IRQ_RST_DONE] = is_rst;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            oper_enable <= `CSH_RST_REG8;
            ques_enable <= `CSH_RST_REG8;
            irq_mask <= `CSH_RST_REG8;
            irq_status <= `CSH_RST_REG8;
        end else begin
            if (reg_wr && reg_addr == `CSH_A_OPER_ENABLE) begin
                oper_enable <= reg_wdata;
            end
            if (reg_wr && reg_addr == `CSH_A_QUES_ENABLE) begin
                ques_enable <= reg_wdata;
            end
            if (reg_wr && reg_addr == `CSH_A_IRQ_MASK) begin
                irq_mask <= reg_wdata;
            end
            if (reg_wr && reg_addr == `CSH_A_IRQ_STATUS) begin
                irq_status <= (irq_status & ~reg_wdata) | irq_evt;
            end else begin
                irq_status <= irq_status | irq_evt;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status & irq_mask);
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 8'h0;
        end else if (reg_rd) begin
            case (reg_addr)
                `CSH_A_IRQ_STATUS: reg_rdata <= irq_status;
                `CSH_A_IRQ_MASK: reg_rdata <= irq_mask;
                `CSH_A_ESR: reg_rdata <= esr;
                `CSH_A_STB: reg_rdata <= stb;
                `CSH_A_OPER_EVENT: reg_rdata <= oper_event;
                `CSH_A_OPER_ENABLE: reg_rdata <= oper_enable;
                `CSH_A_QUES_EVENT: reg_rdata <= ques_event;
                `CSH_A_QUES_ENABLE: reg_rdata <= ques_enable;
                `CSH_A_ERR_COUNT: reg_rdata <= {4'h0, err_count};
                `CSH_A_OPC_STATE: reg_rdata <= {7'h0, opc_armed};
                default: reg_rdata <= 8'h0;
            endcase
        end else begin
            reg_rdata <= 8'h0;
        end
    end
endmodule // csh_handler

// ### verif/csh_monitor.sv
// Port checks of the common command handler.
`include "csh_regs.svh"
module csh_monitor (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic rx_valid,
    input wire logic rx_ready,
    input wire csh_pkg::csh_byte_t tx_data,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic selftest_start,
    input wire csh_pkg::csh_level_t voltage_setpoint,
    input wire csh_pkg::csh_level_t current_setpoint,
    input wire csh_pkg::csh_level_t overvoltage_limit,
    input wire csh_pkg::csh_level_t overcurrent_limit,
    input wire logic output_on,
    input wire logic reg_rd,
    input wire csh_pkg::csh_byte_t reg_rdata
);
    import csh_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_limit_rated: assert property (
        overvoltage_limit == `CSH_LIMIT_V && overcurrent_limit == `CSH_LIMIT_I)
        else $error("limits not at rated plus ten percent");
    a_level_zero: assert property (
        voltage_setpoint == 16'h0000 && current_setpoint == 16'h0000 && !output_on)
        else $error("setpoint or output not zero");
    a_busy_nostall: assert property (rx_ready && !rx_valid |=> rx_ready)
        else $error("character input stalled");
    a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("answer byte dropped");
    a_answer_runs: assert property (
        tx_valid && tx_ready && tx_data != `CSH_CH_LF |=> tx_valid)
        else $error("answer ended without line feed");
    a_answer_ends: assert property (
        tx_valid && tx_ready && tx_data == `CSH_CH_LF |=> !tx_valid && rx_ready)
        else $error("answer not closed at line feed");
    a_answer_blocks: assert property ($rose(tx_valid) |-> !rx_ready)
        else $error("input open during answer");
    a_test_pulse: assert property (selftest_start |=> !selftest_start && !tx_valid)
        else $error("self test start not a single pulse");
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read slot");
    c_answer_end: cover property (tx_valid && tx_ready && tx_data == `CSH_CH_LF);
    c_selftest: cover property (selftest_start);
    c_reg_read: cover property (reg_rd ##1 reg_rdata != 8'h00);
endmodule // csh_monitor

// ### verif/csh_host.sv
// Remote controller model that sends command lines and reads answers.
module csh_host (
    input wire logic clk,
    output csh_pkg::csh_byte_t rx_data,
    output logic rx_valid,
    input wire logic rx_ready,
    input wire csh_pkg::csh_byte_t tx_data,
    input wire logic tx_valid,
    output logic tx_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    import csh_pkg::*;
    csh_byte_t ans[$];
    int stall;
    initial begin
        rx_data = 8'h00;
        rx_valid = 1'b0;
        tx_ready = 1'b0;
        stall = 0;
    end
    // Holds each character until taken, then shows the inverse on the idle line.
    task automatic send(input string s);
        bit ok;
        int n;
        @(posedge clk);
        for (int i = 0; i < s.len(); i++) begin
            rx_data <= s[i];
            rx_valid <= 1'b1;
            ok = 1'b0;
            n = 0;
            while (!ok && n < 500) begin
                @(negedge clk);
                ok = rx_ready;
                n++;
                @(posedge clk);
            end
        end
        rx_valid <= 1'b0;
        rx_data <= ~s[s.len() - 1];
    endtask
    // Reads answer bytes up to the line feed, refusing some cycles on purpose.
    task automatic get();
        bit last;
        ans.delete();
        last = 1'b0;
        for (int n = 0; n < 500 && !last; n++) begin
            @(posedge clk);
            tx_ready <= (stall % 3 != 1);
            stall++;
            @(negedge clk);
            if (tx_valid && tx_ready) begin
                ans.push_back(tx_data);
                last = (tx_data == 8'h0a);
            end
        end
        @(posedge clk);
        tx_ready <= 1'b0;
    endtask
endmodule // csh_host

// ### verif/tb_top.sv
// Self-checking bench of the common command handler.
`include "csh_regs.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import csh_pkg::*;
    logic clk, arst_n, rx_valid, rx_ready, tx_valid, tx_ready, ops_busy, irq;
    logic selftest_start, selftest_done, selftest_pass, output_on, reg_wr, reg_rd;
    csh_byte_t rx_data, tx_data, oper_set, ques_set, reg_wdata, reg_rdata, ro, rq;
    csh_level_t voltage_setpoint, current_setpoint, overvoltage_limit, overcurrent_limit;
    csh_addr_t reg_addr;
    int n_fail, n_checks, cycles, seed, st_cnt;
    logic [7:0] m_oper, m_ques, en_o, en_q;
    csh_handler csh_handler_i (.clk(clk), .arst_n(arst_n), .rx_data(rx_data),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .ops_busy(ops_busy), .oper_set(oper_set), .ques_set(ques_set),
        .selftest_start(selftest_start), .selftest_done(selftest_done),
        .selftest_pass(selftest_pass), .voltage_setpoint(voltage_setpoint),
        .current_setpoint(current_setpoint), .overvoltage_limit(overvoltage_limit),
        .overcurrent_limit(overcurrent_limit), .output_on(output_on), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .irq(irq));
    csh_host csh_host_i (.clk(clk), .rx_data(rx_data), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Answers a self test start after a few cycles.
    always @(posedge clk) begin
        if (selftest_start) begin
            st_cnt <= 5;
        end else if (st_cnt > 0) begin
            st_cnt <= st_cnt - 1;
        end
        selftest_done <= (st_cnt == 1);
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            n_fail++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("checks %0d, mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input csh_addr_t a, input csh_byte_t d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd_chk(input string what, input csh_addr_t a, input csh_byte_t exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        chk(what, {8'h00, exp}, {8'h00, reg_rdata});
    endtask
    task automatic ask(input string cmd, input string exp);
        csh_host_i.send(cmd);
        csh_host_i.get();
        chk("answer length", exp.len(), csh_host_i.ans.size());
        for (int i = 0; i < exp.len() && i < csh_host_i.ans.size(); i++) begin
            chk("answer byte", exp[i], csh_host_i.ans[i]);
        end
    endtask
    initial begin
        {n_fail, n_checks, cycles, st_cnt, seed} = {32'd0, 32'd0, 32'd0, 32'd0, 32'd4};
        {ops_busy, oper_set, ques_set, selftest_done, selftest_pass} = 19'h0;
        {reg_addr, reg_wdata, reg_wr, reg_rd, m_oper, m_ques} = 30'h0;
        arst_n = 1'b0;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        repeat (2) @(negedge clk);
        chk("voltage limit", `CSH_LIMIT_V, overvoltage_limit);
        chk("voltage setpoint", 16'h0000, voltage_setpoint);
        csh_host_i.send("*RST\n");
        rd_chk("irq status", `CSH_A_IRQ_STATUS, 8'h08);
        wr(`CSH_A_IRQ_STATUS, 8'hff);
        en_o = $random(seed);
        en_q = $random(seed);
        wr(`CSH_A_OPER_ENABLE, en_o);
        wr(`CSH_A_QUES_ENABLE, en_q);
        wr(`CSH_A_IRQ_MASK, 8'h0f);
        rd_chk("unmapped", 4'hf, 8'h00);
        ask("*IDN?\n", `CSH_IDN_STR);
        repeat (2) @(negedge clk);
        chk("irq", 1'b1, irq);
        wr(`CSH_A_IRQ_MASK, 8'h00);
        repeat (2) @(negedge clk);
        chk("irq masked", 1'b0, irq);
        wr(`CSH_A_IRQ_MASK, 8'h0f);
        wr(`CSH_A_IRQ_STATUS, 8'hff);
        repeat (2) @(negedge clk);
        chk("irq cleared", 1'b0, irq);
        @(posedge clk);
        ops_busy <= 1'b1;
        csh_host_i.send("*OPC\n");
        rd_chk("esr", `CSH_A_ESR, 8'h00);
        rd_chk("opc pending", `CSH_A_OPC_STATE, 8'h01);
        ask("*opc?\n", "0\n");
        @(posedge clk);
        ops_busy <= 1'b0;
        rd_chk("esr", `CSH_A_ESR, 8'h01);
        ask("*OPC?\n", "1\n");
        ask("*ESR?\n", "1\n");
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            ro = $random(seed);
            rq = $random(seed);
            oper_set <= ro;
            ques_set <= rq;
            m_oper = m_oper | ro;
            m_ques = m_ques | rq;
        end
        @(posedge clk);
        oper_set <= 8'h00;
        ques_set <= 8'h00;
        csh_host_i.send("*XYZ\n");
        ask(":SYST:ERR?;*OPC?\n", "1\n");
        rd_chk("esr", `CSH_A_ESR, 8'h20);
        rd_chk("errors", `CSH_A_ERR_COUNT, 8'h01);
        rd_chk("oper event", `CSH_A_OPER_EVENT, m_oper);
        rd_chk("ques event", `CSH_A_QUES_EVENT, m_ques);
        rd_chk("status byte", `CSH_A_STB, {|(m_oper & en_o), 3'b010, |(m_ques & en_q), 3'b100});
        csh_host_i.send("*CLS\n");
        rd_chk("esr", `CSH_A_ESR, 8'h00);
        rd_chk("errors", `CSH_A_ERR_COUNT, 8'h00);
        rd_chk("oper event", `CSH_A_OPER_EVENT, 8'h00);
        rd_chk("ques event", `CSH_A_QUES_EVENT, 8'h00);
        rd_chk("status byte", `CSH_A_STB, 8'h00);
        rd_chk("oper enable", `CSH_A_OPER_ENABLE, en_o);
        rd_chk("ques enable", `CSH_A_QUES_ENABLE, en_q);
        for (int p = 1; p >= 0; p--) begin
            @(posedge clk);
            selftest_pass <= p[0];
            ask("*TST?\n", p[0] ? "1\n" : "0\n");
        end
        finish_test();
    end
endmodule // tb_top
bind csh_handler csh_monitor csh_monitor_i (.clk(clk), .arst_n(arst_n),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .selftest_start(selftest_start),
    .voltage_setpoint(voltage_setpoint), .current_setpoint(current_setpoint),
    .overvoltage_limit(overvoltage_limit), .overcurrent_limit(overcurrent_limit),
    .output_on(output_on), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
